// ===== hdl/modres_agc_consts.vh
`ifndef MODRES_AGC_CONSTS_VH
`define MODRES_AGC_CONSTS_VH
// register byte addresses
`define ADDR_RESIDUAL_CFG    8'hA7
`define ADDR_RESERVED_SEVEN  8'hA8
`define ADDR_GAIN_LIMITS     8'hA9
`define ADDR_SAMPLES_LOW     8'hAC
`define ADDR_SAMPLES_HIGH    8'hAD
// field positions
`define POS_FULL_STARTUP     5
`define POS_FLOOR_HI         3
`define POS_FLOOR_LO         2
`define POS_CEIL_HI          1
`define POS_CEIL_LO          0
`define POS_MAXGAIN_HI       7
`define POS_MAXGAIN_LO       4
`define POS_BACKOFF_HI       3
`define POS_BACKOFF_LO       0
`define POS_SAMPLES_HI       2
// reset values
`define RST_RESIDUAL_CFG     8'h03
`define RST_RESERVED_SEVEN   8'h01
`define RST_GAIN_LIMITS      8'hC4
`define RST_SAMPLES_LOW      8'h00
`define RST_SAMPLES_HIGH     3'h0
`define RST_FULL_STARTUP     1'b0
`define RST_FLOOR            2'h0
`define RST_CEIL             2'h3
`define RST_MAXGAIN          4'hC
`define RST_BACKOFF          4'h4
// timing: base step in picoseconds, clock period in picoseconds
`define AGC_STEP_PS          1388889
`define CLK_PERIOD_PS        5000
`define AGC_STEP_CYCLES      (`AGC_STEP_PS / `CLK_PERIOD_PS)
`define STARTUP_SAVED_CYCLES 16'h0009
`endif

// ===== hdl/agc_step_timer.v
`timescale 1ns/1ps
// counts (samples+1) x (period+1) base steps, one pulse at the end
module agc_step_timer #(
  parameter STEP_CYCLES = 277,
  parameter CW          = 11,
  parameter PW          = 8
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // control
  input  wire          start,
  input  wire [CW-1:0] sampleCount,
  input  wire [PW-1:0] periodSetting,
  // status
  output reg           busy,
  output reg           done
);
  reg [15:0]   stepCnt_q;
  reg [CW-1:0] sampCnt_q;
  reg [PW-1:0] perCnt_q;

  // nested counters avoid a wide multiplier
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy      <= 1'b0;
      done      <= 1'b0;
      stepCnt_q <= 16'h0000;
      sampCnt_q <= {CW{1'b0}};
      perCnt_q  <= {PW{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy      <= 1'b1;
        stepCnt_q <= 16'h0000;
        sampCnt_q <= sampleCount;
        perCnt_q  <= periodSetting;
      end
      else if (busy)
      begin
        if (stepCnt_q != STEP_CYCLES - 1)
          stepCnt_q <= stepCnt_q + 16'h0001;
        else
        begin
          stepCnt_q <= 16'h0000;
          if (perCnt_q != {PW{1'b0}})
            perCnt_q <= perCnt_q - 1'b1;
          else if (sampCnt_q != {CW{1'b0}})
          begin
            perCnt_q  <= periodSetting;
            sampCnt_q <= sampCnt_q - 1'b1;
          end
          else
          begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ===== hdl/modulator_residual_agc_config.v
// Notes on behaviour
// - full-sample start-up runs the full start, each sample 9 cycles shorter.
// - bits 3:2 set the residual floor 0 to 3; software recalibrates on use.
// - bits 1:0, reset 3, set the residual ceiling 1 to 4; recalibrate after.
// - every channel gain in every step is capped at bits 7:4, reset 0xC.
// - prediction mode lowers gains by bits 3:0, reset 0x4, before it starts.
// - the 11-bit auto-gain sample count spans 0xAC and bits 2:0 of 0xAD.
// - each auto-gain measurement lasts (count+1) x (period+1) steps of 277 cycles of 5 ns, i.e. 1.385 us per step.
// - prediction target is half full scale when clear, a quarter when set.
`timescale 1ns/1ps
`include "modres_agc_consts.vh"
module modulator_residual_agc_config #(
  parameter SAMPLE_CYCLES = 64,
  parameter GAIN_W        = 4,
  parameter PERIOD_W      = 8
) (
  // clock and reset
  input  wire                clk,
  input  wire                rst_n,
  // register port
  input  wire [7:0]          regAddr,
  input  wire [7:0]          regWdata,
  input  wire                regWrite,
  input  wire                regRead,
  output reg  [7:0]          regRdata,
  // sequencer side
  input  wire [PERIOD_W-1:0] samplePeriod,
  input  wire                predictTargetQuarter,
  input  wire                predictMode,
  input  wire                predictStart,
  input  wire [GAIN_W-1:0]   requestedGain,
  input  wire                agcStart,
  input  wire [15:0]         fullScale,
  // configuration outputs
  output reg                 full_sample_startup_enable,
  output reg  [1:0]          residual_floor_limit,
  output reg  [2:0]          residual_ceiling_limit,
  output reg  [GAIN_W-1:0]   appliedGain,
  output reg  [15:0]         predictTarget,
  output reg  [15:0]         sampleCycles,
  output reg  [10:0]         auto_gain_sample_count,
  output reg                 agcBusy,
  output reg                 agcDone
);
  localparam SAMP_W = 16;
  // fields held in flip-flops
  reg              startup_q;
  reg [1:0]        floor_q;
  reg [1:0]        ceil_q;
  reg [3:0]        maxGain_q;
  reg [3:0]        backoff_q;
  reg [7:0]        samplesLow_q;
  reg [2:0]        samplesHigh_q;
  reg [GAIN_W-1:0] gain_d;
  wire             timerBusy;
  wire             timerDone;
  reg [GAIN_W-1:0] gainBack_d;
  reg [7:0]        rdData_d;

  // address decode shared by the write and read paths
  wire             selResidual = (regAddr == `ADDR_RESIDUAL_CFG);
  wire             selReserved = (regAddr == `ADDR_RESERVED_SEVEN);
  wire             selLimits   = (regAddr == `ADDR_GAIN_LIMITS);
  wire             selSampLo   = (regAddr == `ADDR_SAMPLES_LOW);
  wire             selSampHi   = (regAddr == `ADDR_SAMPLES_HIGH);

  // clamp a gain to the ceiling
  function [GAIN_W-1:0] capGain;
    input [GAIN_W-1:0] g;
    input [3:0]        lim;
    begin
      capGain = (g > lim) ? lim : g;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits are never stored
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      startup_q     <= `RST_FULL_STARTUP;
      floor_q       <= `RST_FLOOR;
      ceil_q        <= `RST_CEIL;
      maxGain_q     <= `RST_MAXGAIN;
      backoff_q     <= `RST_BACKOFF;
      samplesLow_q  <= `RST_SAMPLES_LOW;
      samplesHigh_q <= `RST_SAMPLES_HIGH;
    end
    else if (regWrite)
    begin
      // reserved register and unmapped addresses fall through
      if (selResidual)
      begin
        startup_q <= regWdata[`POS_FULL_STARTUP];
        floor_q   <= regWdata[`POS_FLOOR_HI:`POS_FLOOR_LO];
        ceil_q    <= regWdata[`POS_CEIL_HI:`POS_CEIL_LO];
      end
      else if (selLimits)
      begin
        maxGain_q <= regWdata[`POS_MAXGAIN_HI:`POS_MAXGAIN_LO];
        backoff_q <= regWdata[`POS_BACKOFF_HI:`POS_BACKOFF_LO];
      end
      else if (selSampLo)
        samplesLow_q <= regWdata;
      else if (selSampHi)
        samplesHigh_q <= regWdata[`POS_SAMPLES_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read value; unmapped addresses read zero
  always @*
  begin
    rdData_d = 8'h00;
    if (selResidual)
      rdData_d = {2'b00, startup_q, 1'b0, floor_q, ceil_q};
    else if (selReserved)
      rdData_d = `RST_RESERVED_SEVEN;
    else if (selLimits)
      rdData_d = {maxGain_q, backoff_q};
    else if (selSampLo)
      rdData_d = samplesLow_q;
    else if (selSampHi)
      rdData_d = {5'b00000, samplesHigh_q};
    else
      rdData_d = 8'h00;
  end

  // read data stands until the next read strobe
  always @(posedge clk)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= rdData_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // gain path: backoff before prediction, then ceiling, saturating at 0
  always @*
  begin
    gainBack_d = requestedGain;
    if (predictMode && predictStart)
    begin
      if (requestedGain > backoff_q)
        gainBack_d = requestedGain - backoff_q;
      else
        gainBack_d = {GAIN_W{1'b0}};
    end
    gain_d = capGain(gainBack_d, maxGain_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration mirrors, one cycle behind the field registers
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      full_sample_startup_enable <= 1'b0;
      residual_floor_limit       <= 2'h0;
      residual_ceiling_limit     <= 3'h4;
      sampleCycles               <= SAMPLE_CYCLES[SAMP_W-1:0];
      auto_gain_sample_count     <= 11'h000;
    end
    else
    begin
      full_sample_startup_enable <= startup_q;
      residual_floor_limit       <= floor_q;
      // ceiling code 0 means one bit, so the mirror adds one
      residual_ceiling_limit     <= {1'b0, ceil_q} + 3'h1;
      // full start per sample trims the sample length
      sampleCycles <= startup_q ?
                      SAMPLE_CYCLES[SAMP_W-1:0] -
                      `STARTUP_SAVED_CYCLES :
                      SAMPLE_CYCLES[SAMP_W-1:0];
      // both bytes side by side; no latch between the two writes
      auto_gain_sample_count <= {samplesHigh_q, samplesLow_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain and prediction target, registered so both leave from flops
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      appliedGain   <= {GAIN_W{1'b0}};
      predictTarget <= 16'h0000;
    end
    else
    begin
      appliedGain   <= gain_d;
      // half or quarter of full scale
      predictTarget <= predictTargetQuarter ?
                       {2'b00, fullScale[15:2]} :
                       {1'b0, fullScale[15:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer status re-registered; done and the busy drop share one edge
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      agcBusy <= 1'b0;
      agcDone <= 1'b0;
    end
    else
    begin
      agcBusy <= timerBusy;
      agcDone <= timerDone;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement duration timer
  agc_step_timer #(
    .STEP_CYCLES (`AGC_STEP_CYCLES),
    .CW          (11),
    .PW          (PERIOD_W)
  ) u_timer (
    .clk           (clk),
    .rst_n         (rst_n),
    .start         (agcStart),
    .sampleCount   ({samplesHigh_q, samplesLow_q}),
    .periodSetting (samplePeriod),
    .busy          (timerBusy),
    .done          (timerDone)
  );
endmodule

// ===== dv/modres_agc_chk.sv
`timescale 1ns/1ps
module modres_agc_chk #(
  parameter SAMPLE_CYCLES = 64
) (
  // clock and reset
  input logic        clk,
  input logic        rst_n,
  // register port
  input logic [7:0]  regAddr,
  input logic [7:0]  regWdata,
  input logic        regWrite,
  input logic        regRead,
  input logic [7:0]  regRdata,
  // sequencer side
  input logic [7:0]  samplePeriod,
  input logic        predictTargetQuarter,
  input logic [3:0]  requestedGain,
  input logic [15:0] fullScale,
  // configuration outputs
  input logic        full_sample_startup_enable,
  input logic [1:0]  residual_floor_limit,
  input logic [2:0]  residual_ceiling_limit,
  input logic [3:0]  appliedGain,
  input logic [15:0] predictTarget,
  input logic [15:0] sampleCycles,
  input logic [10:0] auto_gain_sample_count,
  input logic        agcBusy,
  input logic        agcDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // decoded writes, two edges of latency to the outputs
  wire wrResidual = regWrite && regAddr == 8'hA7;
  wire wrCountLow = regWrite && regAddr == 8'hAC;
  ////////////////////////////////////////////////////////////////////////////
  AST_START: assert property (wrResidual |-> ##2
    full_sample_startup_enable == $past(regWdata[5], 2)) else $error("start");
  AST_CYC: assert property ($rose(full_sample_startup_enable) |->
    ##[0:1] sampleCycles == SAMPLE_CYCLES - 9) else $error("cycles");
  AST_FLOOR: assert property (wrResidual |-> ##2
    residual_floor_limit == $past(regWdata[3:2], 2)) else $error("floor");
  AST_CEIL: assert property (wrResidual |-> ##2
    residual_ceiling_limit == $past(regWdata[1:0], 2) + 3'h1)
    else $error("ceiling");
  // backoff and cap only ever lower the gain
  AST_GAIN: assert property (appliedGain <= $past(requestedGain))
    else $error("gain");
  AST_CNT: assert property (wrCountLow |-> ##2
    auto_gain_sample_count[7:0] == $past(regWdata, 2)) else $error("count");
  AST_TIME: assert property ($rose(agcBusy) && samplePeriod == 8'h00 &&
    auto_gain_sample_count == 11'h000 |-> ##[275:279] agcDone)
    else $error("agc time");
  AST_DONE: assert property (agcDone |-> $fell(agcBusy))
    else $error("done");
  AST_TGT: assert property ($past(rst_n) |->
    predictTarget == ($past(predictTargetQuarter) ?
    $past(fullScale) >> 2 : $past(fullScale) >> 1)) else $error("target");
  AST_RSV: assert property (regRead && regAddr == 8'hA8 |=>
    regRdata == 8'h01) else $error("reserved");
  // main scenarios reached
  cover property (agcDone);
  cover property (wrResidual);
  cover property (regRead && regAddr == 8'hA8);
endmodule
bind modulator_residual_agc_config modres_agc_chk
  #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) uChk (.*);

// ===== dv/modulator_residual_agc_config_bench.sv
`timescale 1ns/1ps
module modulator_residual_agc_config_bench;
  // stimulus, all driven from time zero
  logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, samplePeriod = 8'h00;
  logic predictTargetQuarter = 1'b0, predictMode = 1'b0;
  logic predictStart = 1'b0, agcStart = 1'b0;
  logic [3:0] requestedGain = 4'h0;
  logic [15:0] fullScale = 16'h1000;
  // observed
  logic [7:0] regRdata;
  logic full_sample_startup_enable, agcBusy, agcDone;
  logic [1:0] residual_floor_limit;
  logic [2:0] residual_ceiling_limit;
  logic [3:0] appliedGain;
  logic [15:0] predictTarget, sampleCycles;
  logic [10:0] auto_gain_sample_count;
  int fails = 0, n_tests = 0, i;
  modulator_residual_agc_config dut (.*);
  // 200 MHz
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write, then let the two-edge output latency pass
  task wr(input logic [7:0] a, d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge clk);
    #1 regWrite = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task rd(input logic [7:0] a, e);
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk);
    #1 regRead = 1'b0;
    chk("regRdata", e, regRdata);
    // idle edge so back-to-back reads never retoggle the strobe
    @(posedge clk);
    #1;
  endtask
  task gain(input logic [3:0] g, input logic m, input logic [3:0] e);
    requestedGain = g;
    predictMode = m;
    predictStart = m;
    repeat (2) @(posedge clk);
    #1 chk("appliedGain", e, appliedGain);
  endtask
  // busy cycles counted until the done pulse, bounded
  task agc(input logic [10:0] n, input logic [7:0] p);
    int k, c;
    wr(8'hAC, n[7:0]);
    wr(8'hAD, {5'h00, n[10:8]});
    samplePeriod = p;
    agcStart = 1'b1;
    @(posedge clk);
    #1 agcStart = 1'b0;
    c = 0;
    for (k = 0; k < 5000 && agcDone !== 1'b1; k++)
    begin
      c += (agcBusy === 1'b1);
      @(posedge clk);
      #1;
    end
    if (k == 5000)
    begin
      fails++;
      complete_run;
    end
    else
      chk("agcTime", 16'((n + 1) * (p + 1) * 277), 16'(c));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("ceiling", 3'h4, residual_ceiling_limit);
    chk("sampleCycles", 16'h0040, sampleCycles);
    rd(8'hA7, 8'h03);
    rd(8'hA9, 8'hC4);
    rd(8'hAD, 8'h00);
    rd(8'hB0, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(8'hA7, 8'(i * 5));
      chk("floor", 16'(i), residual_floor_limit);
      chk("ceiling", 16'(i + 1), residual_ceiling_limit);
    end
    wr(8'hA7, 8'hFF);
    chk("startup", 1'b1, full_sample_startup_enable);
    chk("sampleCycles", 16'h0037, sampleCycles);
    rd(8'hA7, 8'h2F);
    wr(8'hA8, 8'hFE);
    rd(8'hA8, 8'h01);
    wr(8'hA9, 8'h75);
    rd(8'hA9, 8'h75);
    gain(4'hF, 1'b0, 4'h7);
    gain(4'h6, 1'b0, 4'h6);
    gain(4'h6, 1'b1, 4'h1);
    gain(4'h3, 1'b1, 4'h0);
    wr(8'hAC, 8'hFF);
    wr(8'hAD, 8'hFF);
    chk("count", 16'h07FF, auto_gain_sample_count);
    rd(8'hAD, 8'h07);
    for (i = 0; i < 2; i++)
    begin
      predictTargetQuarter = i[0];
      repeat (2) @(posedge clk);
      #1 chk("target", 16'h1000 >> (i + 1), predictTarget);
    end
    agc(11'h000, 8'h00);
    agc(11'h001, 8'h01);
    complete_run;
  end
endmodule
